// ==== pbcs_pkg.sv ====
// Shared constants of the base clock selector and its system-side partner
package pbcs_pkg;

  // Data and address widths
  localparam int unsigned DATA_W     = 8;
  localparam int unsigned DEV_ADDR_W = 1;
  localparam int unsigned SW_ADDR_W  = 3;

  // Device register indices
  localparam logic [DEV_ADDR_W-1:0] DEV_CTRL_ADDR = 1'h0;
  localparam logic [DEV_ADDR_W-1:0] DEV_PROG_ADDR = 1'h1;

  // Control register field positions
  localparam int unsigned CTRL_IE_BIT  = 7;
  localparam int unsigned CTRL_FLG_BIT = 6;
  localparam int unsigned CTRL_ON_BIT  = 5;
  localparam int unsigned CTRL_BCS_BIT = 4;
  localparam logic [3:0]  CTRL_UNUSED_RD = 4'hF;

  // Programming register fields and reset value
  localparam int unsigned PROG_MUL_HI = 7;
  localparam int unsigned PROG_MUL_LO = 4;
  localparam int unsigned PROG_RNG_HI = 3;
  localparam int unsigned PROG_RNG_LO = 0;
  localparam logic [DATA_W-1:0] PROG_RESET = 8'h66;
  localparam logic [3:0] MUL_ZERO = 4'h0;
  localparam logic [3:0] MUL_ONE  = 4'h1;
  localparam logic [3:0] RNG_ZERO = 4'h0;

  // Control reset values
  localparam logic RST_PLL_ON = 1'b1;
  localparam logic RST_BCS    = 1'b0;
  localparam logic RST_IE     = 1'b0;

  // Source edges to wait for on a switch-over, per source
  localparam int unsigned SWITCH_EDGES = 3;
  localparam int unsigned SWITCH_CNT_W = 2;

  // Synchroniser lanes
  localparam int unsigned SYNC_LANES = 3;
  localparam int unsigned LANE_XTAL  = 0;
  localparam int unsigned LANE_VCO   = 1;
  localparam int unsigned LANE_LOCK  = 2;

  // Host register map
  localparam logic [SW_ADDR_W-1:0] SW_DEV_CTRL = 3'h0;
  localparam logic [SW_ADDR_W-1:0] SW_DEV_PROG = 3'h1;
  localparam logic [SW_ADDR_W-1:0] SW_HCTRL    = 3'h2;
  localparam logic [SW_ADDR_W-1:0] SW_IRQ_STAT = 3'h3;
  localparam logic [SW_ADDR_W-1:0] SW_IRQ_MASK = 3'h4;
  localparam logic [SW_ADDR_W-1:0] SW_HSTAT    = 3'h5;

  // Host register fields
  localparam int unsigned HCTRL_OSC_BIT = 0;
  localparam int unsigned IRQ_LOCK_BIT  = 0;
  localparam int unsigned IRQ_W         = 1;
  localparam int unsigned HSTAT_IRQ_BIT = 0;
  localparam int unsigned HSTAT_BUS_BIT = 1;
  localparam int unsigned HSTAT_BASE_BIT = 2;
  localparam logic RST_OSC_EN = 1'b1;

  // Transition control states
  typedef enum logic [0:0] {ST_RUN, ST_WAIT} pbcs_state_e;

endpackage

// ==== pbcs_if.sv ====
// Interface joining the clock selector device and its system-side partner
`timescale 1ns/1ps
`default_nettype none
interface pbcs_if;
  import pbcs_pkg::*;

  // Register access from the system side
  logic [DEV_ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0]     reg_wdata;
  logic                  reg_wr;
  logic                  reg_rd;
  logic [DATA_W-1:0]     reg_rdata;
  // System control and device results
  logic                  osc_enable_in;
  logic                  pll_interrupt;
  logic                  base_clock_out;
  logic                  bus_clock_out;

  modport dev (
    input  reg_addr, reg_wdata, reg_wr, reg_rd, osc_enable_in,
    output reg_rdata, pll_interrupt, base_clock_out, bus_clock_out
  );

  modport host (
    output reg_addr, reg_wdata, reg_wr, reg_rd, osc_enable_in,
    input  reg_rdata, pll_interrupt, base_clock_out, bus_clock_out
  );
endinterface
`default_nettype wire

// ==== pbcs_host.sv ====
// System-side partner: software port, forwarding to the device, interrupt status
`timescale 1ns/1ps
`default_nettype none
module pbcs_host (
  // Clock and reset
  input  wire logic                           sys_clk,
  input  wire logic                           resetn,
  // Device link
  pbcs_if.host                                link,
  // Software port
  input  wire logic [pbcs_pkg::SW_ADDR_W-1:0] sw_addr,
  input  wire logic [pbcs_pkg::DATA_W-1:0]    sw_wdata,
  input  wire logic                           sw_wr,
  input  wire logic                           sw_rd,
  output logic      [pbcs_pkg::DATA_W-1:0]    sw_rdata,
  // Interrupt
  output logic                                irq
);
  import pbcs_pkg::*;

  logic                 osc_en_q;
  logic [IRQ_W-1:0]     stat_q;
  logic [IRQ_W-1:0]     mask_q;
  logic                 dev_irq_q;
  logic [DATA_W-1:0]    own_rdata_q;
  logic                 dev_sel_q;
  logic                 dev_hit;
  logic                 lock_evt;

  // Both device registers sit in the low two host offsets
  assign dev_hit = (sw_addr == SW_DEV_CTRL) || (sw_addr == SW_DEV_PROG);

  // Device accesses pass straight through; the device answers one cycle later
  assign link.reg_addr      = sw_addr[DEV_ADDR_W-1:0];
  assign link.reg_wdata     = sw_wdata;
  assign link.reg_wr        = sw_wr & dev_hit;
  assign link.reg_rd        = sw_rd & dev_hit;
  assign link.osc_enable_in = osc_en_q;

  // Oscillator enable, steered by software
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      osc_en_q <= RST_OSC_EN;
    else if (sw_wr && sw_addr == SW_HCTRL)
      osc_en_q <= sw_wdata[HCTRL_OSC_BIT];
  end

  // Rising edge of the device interrupt is the lock-change event
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      dev_irq_q <= 1'b0;
    else
      dev_irq_q <= link.pll_interrupt;
  end
  assign lock_evt = link.pll_interrupt & ~dev_irq_q;

  // Sticky status, write one to clear; a new event beats the clear
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      stat_q <= '0;
    else if (lock_evt)
      stat_q[IRQ_LOCK_BIT] <= 1'b1;
    else if (sw_wr && sw_addr == SW_IRQ_STAT)
      stat_q <= stat_q & ~sw_wdata[IRQ_W-1:0];
  end

  // Interrupt mask
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      mask_q <= '0;
    else if (sw_wr && sw_addr == SW_IRQ_MASK)
      mask_q <= sw_wdata[IRQ_W-1:0];
  end

  assign irq = |(stat_q & mask_q);

  // Own read data, registered; device reads are taken from the device's flop
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      own_rdata_q <= '0;
      dev_sel_q   <= 1'b0;
    end
    else
    begin
      dev_sel_q   <= sw_rd & dev_hit;
      own_rdata_q <= '0;
      if (sw_rd)
      begin
        if (sw_addr == SW_HCTRL)
          own_rdata_q[HCTRL_OSC_BIT] <= osc_en_q;
        else if (sw_addr == SW_IRQ_STAT)
          own_rdata_q[IRQ_W-1:0] <= stat_q;
        else if (sw_addr == SW_IRQ_MASK)
          own_rdata_q[IRQ_W-1:0] <= mask_q;
        else if (sw_addr == SW_HSTAT)
        begin
          own_rdata_q[HSTAT_IRQ_BIT]  <= link.pll_interrupt;
          own_rdata_q[HSTAT_BUS_BIT]  <= link.bus_clock_out;
          own_rdata_q[HSTAT_BASE_BIT] <= link.base_clock_out;
        end
      end
    end
  end

  assign sw_rdata = dev_sel_q ? link.reg_rdata : own_rdata_q;

endmodule
`default_nettype wire

// ==== pbcs_dev.sv ====
// Base clock selector device: control registers, interlocks and glitch-free switch-over
// Function
// - Zero multiplier behaves as multiplier one
// - Zero range disables PLL, forces crystal
// - Switch waits three edges each, output frozen; the VCO wait is skipped while the PLL is off
// - Selected source divided by two, even duty
// - Bus clock is half the base clock
// - Select bit chooses crystal or VCO source
// - VCO selection refused while PLL off
// - PLL stays on while VCO selected
// - One write cannot change enable and select
// - Software writes multiplier to upper nibble
// - Software writes range to lower nibble
// - Oscillator enable gates crystal and PLL
// - Interrupt output comes from lock detector
// - Software computes multiplier from target frequency
// - Software computes range from nominal center
// - PLL enable runs the loop, set at reset
//
// Decided for this implementation: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module pbcs_dev (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  // System link
  pbcs_if.dev              link,
  // Analog side: source clocks and lock detector
  input  wire logic        crystal_clock,
  input  wire logic        vco_clock,
  input  wire logic        pll_lock_in,
  // Analog side: enables and decoded settings
  output logic             pll_enable_out,
  output logic             xosc_enable_out,
  output logic [3:0]       mult_n_out,
  output logic [3:0]       range_l_out
);
  import pbcs_pkg::*;

  // Zero in the multiplier field programs the divider like one
  function automatic logic [3:0] decode_mult(input logic [3:0] field);
    decode_mult = (field == MUL_ZERO) ? MUL_ONE : field;
  endfunction

  logic [SYNC_LANES-1:0]   s1_q;
  logic [SYNC_LANES-1:0]   s2_q;
  logic [SYNC_LANES-1:0]   s3_q;
  logic [SYNC_LANES-1:0]   flt_q;
  logic [SYNC_LANES-1:0]   agree;
  logic [SYNC_LANES-1:0]   rise;
  logic                    lock_toggle;

  logic                    pll_on_q;
  logic                    bcs_q;
  logic                    ie_q;
  logic                    flg_q;
  logic [DATA_W-1:0]       prog_q;
  logic [DATA_W-1:0]       rdata_q;

  logic                    wr_ctrl;
  logic                    wr_prog;
  logic                    rd_ctrl;
  logic                    range_ok;
  logic                    osc_en;
  logic                    bcs_allowed;

  pbcs_state_e             state_q;
  logic                    src_vco_q;
  logic [SWITCH_CNT_W-1:0] xcnt_q;
  logic [SWITCH_CNT_W-1:0] vcnt_q;
  logic                    x_done;
  logic                    v_done;
  logic                    src_rise;
  logic                    base_q;
  logic                    bus_q;

  // Source clocks and lock level come from other domains: three flops each
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end
    else
    begin
      s1_q <= {pll_lock_in, vco_clock, crystal_clock};
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // A level counts only once the second and third flops agree
  assign agree = ~(s2_q ^ s3_q);
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      flt_q <= '0;
    else
      flt_q <= (agree & s3_q) | (~agree & flt_q);
  end

  assign rise        = agree & s3_q & ~flt_q;
  assign lock_toggle = agree[LANE_LOCK] & (s3_q[LANE_LOCK] != flt_q[LANE_LOCK]);

  // Access decode
  assign wr_ctrl  = link.reg_wr & (link.reg_addr == DEV_CTRL_ADDR);
  assign wr_prog  = link.reg_wr & (link.reg_addr == DEV_PROG_ADDR);
  assign rd_ctrl  = link.reg_rd & (link.reg_addr == DEV_CTRL_ADDR);
  assign osc_en   = link.osc_enable_in;
  assign range_ok = prog_q[PROG_RNG_HI:PROG_RNG_LO] != RNG_ZERO;

  // VCO may be chosen only if the PLL is on now and stays on in this write
  assign bcs_allowed = pll_on_q & link.reg_wdata[CTRL_ON_BIT] & range_ok & osc_en;

  // PLL enable: set at reset, cannot drop while the VCO is selected
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      pll_on_q <= RST_PLL_ON;
    else if (wr_ctrl)
      pll_on_q <= link.reg_wdata[CTRL_ON_BIT] | bcs_q;
  end

  // Source select bit; zero range or a stopped oscillator forces the crystal.
  // A select bit already set is kept by writing one again, so a refused turn-off leaves the VCO driving
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      bcs_q <= RST_BCS;
    else if (!range_ok || !osc_en)
      bcs_q <= 1'b0;
    else if (wr_ctrl)
      bcs_q <= link.reg_wdata[CTRL_BCS_BIT] & (bcs_q | bcs_allowed);
  end

  // Interrupt enable
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      ie_q <= RST_IE;
    else if (wr_ctrl)
      ie_q <= link.reg_wdata[CTRL_IE_BIT];
  end

  // Lock-change flag: cleared by reading control, but a toggle in that cycle wins
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      flg_q <= 1'b0;
    else if (lock_toggle && pll_enable_out)
      flg_q <= 1'b1;
    else if (rd_ctrl)
      flg_q <= 1'b0;
  end

  assign link.pll_interrupt = flg_q & ie_q;

  // Programming register: frozen while the PLL is on, so the loop is never retuned live
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      prog_q <= PROG_RESET;
    else if (wr_prog && !pll_on_q)
      prog_q <= link.reg_wdata;
  end

  // Read data one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      rdata_q <= '0;
    else if (link.reg_rd)
    begin
      if (link.reg_addr == DEV_CTRL_ADDR)
        rdata_q <= {ie_q, flg_q, pll_on_q, bcs_q, CTRL_UNUSED_RD};
      else if (link.reg_addr == DEV_PROG_ADDR)
        rdata_q <= prog_q;
      else
        rdata_q <= '0;
    end
  end
  assign link.reg_rdata = rdata_q;

  // Analog controls, registered
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      pll_enable_out  <= 1'b0;
      xosc_enable_out <= 1'b0;
      mult_n_out      <= MUL_ONE;
      range_l_out     <= RNG_ZERO;
    end
    else
    begin
      pll_enable_out  <= pll_on_q & range_ok & osc_en;
      xosc_enable_out <= osc_en;
      mult_n_out      <= decode_mult(prog_q[PROG_MUL_HI:PROG_MUL_LO]);
      range_l_out     <= prog_q[PROG_RNG_HI:PROG_RNG_LO];
    end
  end

  // A stopped VCO never delivers edges, so its wait is skipped when the PLL is off
  assign x_done = xcnt_q == SWITCH_CNT_W'(SWITCH_EDGES);
  assign v_done = (vcnt_q == SWITCH_CNT_W'(SWITCH_EDGES)) || !pll_enable_out;

  // Transition control: freeze, count three edges of each source (the VCO only while the PLL is on), then hand over
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_q   <= ST_RUN;
      src_vco_q <= 1'b0;
      xcnt_q    <= '0;
      vcnt_q    <= '0;
    end
    else
    begin
      case (state_q)
        ST_RUN:
        begin
          xcnt_q <= '0;
          vcnt_q <= '0;
          if (bcs_q != src_vco_q)
            state_q <= ST_WAIT;
        end
        ST_WAIT:
        begin
          if (rise[LANE_XTAL] && !x_done)
            xcnt_q <= xcnt_q + 1'b1;
          if (rise[LANE_VCO] && !v_done)
            vcnt_q <= vcnt_q + 1'b1;
          if (x_done && v_done)
          begin
            src_vco_q <= bcs_q;
            state_q   <= ST_RUN;
          end
        end
        default:
          state_q <= ST_RUN;
      endcase
    end
  end

  // Only whole source edges advance the divider, so no phase is ever cut short
  assign src_rise = (state_q == ST_RUN) && (bcs_q == src_vco_q) &&
                    (src_vco_q ? rise[LANE_VCO] : rise[LANE_XTAL]);

  // Base clock toggles per source rising edge; bus clock toggles per base rising edge
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      base_q <= 1'b0;
      bus_q  <= 1'b0;
    end
    else if (src_rise)
    begin
      base_q <= ~base_q;
      if (!base_q)
        bus_q <= ~bus_q;
    end
  end

  assign link.base_clock_out = base_q;
  assign link.bus_clock_out  = bus_q;

endmodule
`default_nettype wire

// ==== pbcs_properties.sv ====
// Checker of the link between the clock selector and its system-side partner
`timescale 1ns/1ps
`default_nettype none
module pbcs_properties (
  // Clock and reset
  input wire logic                            sys_clk,
  input wire logic                            resetn,
  // Link signals
  input wire logic [pbcs_pkg::DEV_ADDR_W-1:0] reg_addr,
  input wire logic [pbcs_pkg::DATA_W-1:0]     reg_wdata,
  input wire logic                            reg_wr,
  input wire logic                            reg_rd,
  input wire logic [pbcs_pkg::DATA_W-1:0]     reg_rdata,
  input wire logic                            osc_enable_in,
  input wire logic                            pll_interrupt,
  input wire logic                            base_clock_out,
  input wire logic                            bus_clock_out
);
  import pbcs_pkg::*;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  // Control read strobe; its data lands one cycle later
  wire ctl_rd = reg_rd && (reg_addr == DEV_CTRL_ADDR);

  a_bus_on_rise: assert property ($changed(bus_clock_out) |->
    (base_clock_out && !$past(base_clock_out)) || ($past(base_clock_out) && !$past(base_clock_out, 2)))
    else $error("bus clock moved away from a base rise");
  a_bus_half_rate: assert property ($changed(bus_clock_out) |=> $stable(bus_clock_out)[*8])
    else $error("bus clock phase too short");
  // Sources in this bench are at least 8 cycles a period, so no phase may be shorter than 7
  a_base_high_whole: assert property ($rose(base_clock_out) |=> base_clock_out[*6])
    else $error("base clock high phase shortened");
  a_base_low_whole: assert property ($fell(base_clock_out) |=> !base_clock_out[*6])
    else $error("base clock low phase shortened");
  a_select_needs_on: assert property (ctl_rd |=> !reg_rdata[CTRL_BCS_BIT] || reg_rdata[CTRL_ON_BIT])
    else $error("vco selected with pll off");
  a_irq_from_flag: assert property (ctl_rd |=>
    (reg_rdata[CTRL_IE_BIT] && reg_rdata[CTRL_FLG_BIT]) == $past(pll_interrupt))
    else $error("interrupt disagrees with flag and enable");
  a_range_zero_xtal: assert property ((reg_rd && reg_addr == DEV_PROG_ADDR) ##1
    (reg_rdata[3:0] == RNG_ZERO && ctl_rd) |=> !reg_rdata[CTRL_BCS_BIT])
    else $error("vco selected with zero range");
  a_osc_off_xtal: assert property (!osc_enable_in ##1 (!osc_enable_in && ctl_rd) |=>
    !reg_rdata[CTRL_BCS_BIT])
    else $error("vco selected with oscillator off");

  c_vco_selected: cover property (ctl_rd ##1 reg_rdata[CTRL_BCS_BIT]);
  c_lock_irq: cover property ($rose(pll_interrupt));
  c_bus_moves: cover property ($changed(bus_clock_out));
endmodule
`default_nettype wire

// ==== test_pll_base_clock_selector.sv ====
// Bench of the clock selector device and its system-side partner
`timescale 1ns/1ps
`default_nettype none
module test_pll_base_clock_selector;
  import pbcs_pkg::*;
  logic                 sys_clk = 1'b0;
  logic                 resetn = 1'b0;
  logic                 crystal_clock = 1'b0;
  logic                 vco_clock = 1'b0;
  logic                 pll_lock_in = 1'b0;
  logic [SW_ADDR_W-1:0] sw_addr = 3'h0;
  logic [DATA_W-1:0]    sw_wdata = 8'h00;
  logic                 sw_wr = 1'b0;
  logic                 sw_rd = 1'b0;
  logic [DATA_W-1:0]    sw_rdata;
  logic                 irq;
  logic                 pll_en;
  logic                 xosc_en;
  logic [3:0]           mult_n;
  logic [3:0]           range_l;
  logic [7:0]           held;
  int                   failures = 0;
  int                   cmp_count = 0;
  int                   cycles = 0;

  // Clocks: crystal 12 cycles a period, vco 8, off phase with the system clock
  initial forever #2 sys_clk = ~sys_clk;
  // Whole periods keep every phase of the divided clocks an exact cycle count
  always #24 crystal_clock = ~crystal_clock;
  always #16 vco_clock = ~vco_clock;

  pbcs_if pbcs_if_i ();
  pbcs_host pbcs_host_i (.sys_clk(sys_clk), .resetn(resetn), .link(pbcs_if_i), .sw_addr(sw_addr),
    .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata), .irq(irq));
  pbcs_dev pbcs_dev_i (.sys_clk(sys_clk), .resetn(resetn), .link(pbcs_if_i), .crystal_clock(crystal_clock),
    .vco_clock(vco_clock), .pll_lock_in(pll_lock_in), .pll_enable_out(pll_en), .xosc_enable_out(xosc_en),
    .mult_n_out(mult_n), .range_l_out(range_l));
  pbcs_properties pbcs_properties_i (.sys_clk(sys_clk), .resetn(resetn), .reg_addr(pbcs_if_i.reg_addr),
    .reg_wdata(pbcs_if_i.reg_wdata), .reg_wr(pbcs_if_i.reg_wr), .reg_rd(pbcs_if_i.reg_rd),
    .reg_rdata(pbcs_if_i.reg_rdata), .osc_enable_in(pbcs_if_i.osc_enable_in),
    .pll_interrupt(pbcs_if_i.pll_interrupt), .base_clock_out(pbcs_if_i.base_clock_out),
    .bus_clock_out(pbcs_if_i.bus_clock_out));

  task automatic give_verdict();
    $display("compares %0d, mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp)
      failures++;
    if (seen !== exp)
      $display("[ERR] %0t saw %h expected %h", $time, seen, exp);
  endtask

  // Step to just after the next edge so registered outputs have settled
  task automatic tick();
    @(posedge sys_clk);
    #1;
  endtask

  task automatic sw_write(input logic [2:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    sw_addr <= a;
    sw_wdata <= d;
    sw_wr <= 1'b1;
    @(posedge sys_clk);
    sw_wr <= 1'b0;
  endtask

  // Read data is only promised in the cycle after the strobe
  task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    sw_addr <= a;
    sw_rd <= 1'b1;
    @(posedge sys_clk);
    sw_rd <= 1'b0;
    #1 check(sw_rdata, exp);
  endtask

  function automatic logic pick(input bit bus);
    return bus ? pbcs_if_i.bus_clock_out : pbcs_if_i.base_clock_out;
  endfunction

  // Length in cycles of one high phase of base or bus clock
  task automatic high_len(input bit bus, input int exp);
    int n;
    n = 0;
    while (pick(bus) !== 1'b0) tick();
    while (pick(bus) !== 1'b1) tick();
    while (pick(bus) === 1'b1 && n < 200)
    begin
      tick();
      n++;
    end
    check(8'(n), 8'(exp));
  endtask

  // Main sequence
  initial
  begin
    repeat (5) @(posedge sys_clk);
    resetn <= 1'b1;
    tick();
    check({3'h0, pll_en, mult_n}, 8'h16);
    rd_chk(SW_DEV_CTRL, 8'h2F);
    sw_write(SW_DEV_CTRL, 8'h00);
    rd_chk(SW_DEV_CTRL, 8'h0F);
    sw_write(SW_DEV_CTRL, 8'h10);
    rd_chk(SW_DEV_CTRL, 8'h0F);
    sw_write(SW_DEV_CTRL, 8'h30);
    rd_chk(SW_DEV_CTRL, 8'h2F);
    sw_write(SW_DEV_CTRL, 8'h00);
    sw_write(SW_DEV_PROG, 8'h05);
    tick();
    check({mult_n, range_l}, 8'h15);
    sw_write(SW_DEV_PROG, 8'h70);
    sw_write(SW_DEV_CTRL, 8'h20);
    sw_write(SW_DEV_CTRL, 8'h30);
    tick();
    check({pll_en, 3'h0, mult_n}, 8'h07);
    // Back-to-back reads: programming, then control
    @(posedge sys_clk);
    sw_addr <= SW_DEV_PROG;
    sw_rd <= 1'b1;
    @(posedge sys_clk);
    sw_addr <= SW_DEV_CTRL;
    #1 check(sw_rdata, 8'h70);
    @(posedge sys_clk);
    sw_rd <= 1'b0;
    #1 check(sw_rdata, 8'h2F);
    sw_write(SW_DEV_CTRL, 8'h00);
    sw_write(SW_DEV_PROG, 8'h66);
    sw_write(SW_DEV_CTRL, 8'h20);
    sw_write(SW_DEV_CTRL, 8'h30);
    // Output must hold still while both sources are counted out
    repeat (4) tick();
    held = {7'h00, pbcs_if_i.base_clock_out};
    repeat (16)
    begin
      tick();
      check({7'h00, pbcs_if_i.base_clock_out}, held);
    end
    rd_chk(SW_DEV_CTRL, 8'h3F);
    sw_write(SW_DEV_CTRL, 8'h10);
    rd_chk(SW_DEV_CTRL, 8'h3F);
    high_len(1'b0, 8);
    high_len(1'b1, 16);
    sw_write(SW_DEV_CTRL, 8'h20);
    repeat (60) tick();
    high_len(1'b0, 12);
    // Select the VCO first, so that stopping the oscillator really has to force the crystal back
    sw_write(SW_DEV_CTRL, 8'h30);
    sw_write(SW_HCTRL, 8'h00);
    tick();
    check({6'h00, pll_en, xosc_en}, 8'h00);
    rd_chk(SW_DEV_CTRL, 8'h2F);
    sw_write(SW_HCTRL, 8'h01);
    sw_write(SW_DEV_CTRL, 8'hA0);
    pll_lock_in <= 1'b1;
    repeat (10) tick();
    check({6'h00, pbcs_if_i.pll_interrupt, irq}, 8'h02);
    sw_write(SW_IRQ_MASK, 8'h01);
    tick();
    check({7'h00, irq}, 8'h01);
    rd_chk(SW_DEV_CTRL, 8'hEF);
    sw_write(SW_IRQ_STAT, 8'h01);
    tick();
    check({6'h00, pbcs_if_i.pll_interrupt, irq}, 8'h00);
    sw_write(3'h6, 8'hFF);
    rd_chk(3'h6, 8'h00);
    give_verdict();
  end

  // Watchdog: the sequence needs well under a thousand cycles
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      failures++;
      give_verdict();
    end
  end
endmodule
`default_nettype wire
